//--- shared/ritm_regs.vh
// Constants for the tag-side inventory slot sequencer.
// Assumes a frame decoder upstream and a carrier-derived clock pin.
`ifndef RITM_REGS_VH
`define RITM_REGS_VH

// Request flag bit positions, counted from zero.
`define RITM_FLAG_SLOTS_BIT 5
`define RITM_FLAG_AFI_BIT 4
`define RITM_FLAG_INV_BIT 2

// Command codes that the sequencer tells apart.
`define RITM_CMD_INVENTORY 8'h01
`define RITM_CMD_WRITE 8'h21

// Mask length limits for sixteen slots and for one slot.
`define RITM_MASK_MAX16 8'h3C
`define RITM_MASK_MAX1 8'h40

// Slot geometry for the sixteen-slot case.
`define RITM_SLOT_W16 7'h04
`define RITM_LAST_SLOT16 4'hF

// Response layout: flags, data-format identifier, then the UID bytes.
`define RITM_RESP_FLAGS 8'h00
`define RITM_DSFID 8'h00
`define RITM_RESP_LAST 4'h9

// Delay windows in carrier cycles; the counters tick once per carrier cycle.
`define RITM_T1_MIN 13'h10E0
`define RITM_T1_NOM 13'h1100
`define RITM_T1_MAX 14'h1120
`define RITM_T2_MIN 13'h1060
// Nominal response time of the tag in carrier cycles, plain default.
`define RITM_T_NRT 14'h0400
// Least width of a slot delimiter pulse in carrier cycles, plain default.
`define RITM_EOF_MIN 8'h08

`endif

//--- src/ritm_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the drain side may stall for any number of cycles.
`timescale 1ns/1ns
module ritm_buf2 #(
    parameter W = 9
) (
    input wire clk,
    input wire resetn,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output wire in_ready,
    output reg out_valid,
    output reg [W-1:0] out_data,
    input wire out_ready
);

    reg [1:0] cnt_q;
    reg [W-1:0] tail_q;
    wire push;
    wire pop;

    // The head entry is the output register, so the drain side sees flops only.
    assign in_ready = (cnt_q != 2'h2);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Push and pop in one cycle keep the count; with two entries the tail slides into the head, with one the input goes there.
    always @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= 2'h0;
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
            tail_q <= {W{1'b0}};
        end else begin
            if (push && pop) begin
                if (cnt_q == 2'h1) begin
                    out_data <= in_data;
                end else begin
                    out_data <= tail_q;
                    tail_q <= in_data;
                end
            end else if (pop) begin
                out_data <= tail_q;
                cnt_q <= cnt_q - 2'h1;
                out_valid <= (cnt_q == 2'h2);
            end else if (push) begin
                if (cnt_q == 2'h0) begin
                    out_data <= in_data;
                end else begin
                    tail_q <= in_data;
                end
                cnt_q <= cnt_q + 2'h1;
                out_valid <= 1'b1;
            end
        end
    end

endmodule

//--- src/ritm_inventory.v
// Tag-side inventory slot sequencer with response and ignore timing.
// Assumes a frame decoder on clk gives request bytes, SOF and EOF pulses,
// and that the carrier clock and modulation detectors arrive as raw pins.
//
// Notes on behaviour
// - Slot flag set gives one slot, width zero; else sixteen slots, width four.
// - Slot index starts at zero per inventory and stays within zero to fifteen.
// - Answer only when low UID bits equal slot bits above the mask bits.
// - With one slot, compare only the significant mask bits, not padding.
// - After each slot wait a delimiter; a SOF abandons inventory, decodes anew.
// - Reader EOF steps the slot below the last one, otherwise ends the sequence.
// - A full pulse of the least width counts as EOF between slots; a shallow one only outside the ignore window.
// - Slot zero starts right after the EOF closing the inventory request.
// - Mask goes LSB first in whole bytes, zero padded, next field byte aligned.
// - Request carries flags, command, mask length, mask bytes and CRC.
// - Wait between least and most delay after EOF before answering or stepping.
// - No upper delay limit for write requests; completion sets the timing.
// - Full modulation during the delay restarts it for a whole new delay.
// - Ignore shallow modulation for most delay plus response time after EOF.
// - Slot delimiters may use shallow or full modulation; full is always accepted, shallow only outside the ignore window.
// - Inventory response carries a zero format identifier then the 64-bit UID.
// - A request failing its CRC gets no answer.
// - A new inventory after an interrupted one restarts slots at zero.
`timescale 1ns/1ns
`include "ritm_regs.vh"
module ritm_inventory #(
    parameter [12:0] T1_CYC = `RITM_T1_NOM,
    parameter [13:0] MIT_CYC = `RITM_T1_MAX + `RITM_T_NRT,
    parameter [7:0] EOF_MIN = `RITM_EOF_MIN
) (
    input wire clk,
    input wire resetn,
    input wire carrier_clk,
    input wire mod_full,
    input wire mod_shallow,
    input wire [63:0] uid,
    input wire rx_sof,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_eof,
    input wire rx_crc_ok,
    input wire write_done,
    output wire resp_valid,
    output wire [7:0] resp_data,
    output wire resp_last,
    input wire resp_ready,
    output reg [3:0] slot_index,
    output reg inv_active,
    output reg shallow_ignore,
    output reg reply_go
);

    // Sequencer states; binary codes keep the state register at three bits.
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_SEND = 3'h3;
    localparam [2:0] ST_SLOT = 3'h4;
    localparam [2:0] ST_WRWAIT = 3'h5;

    // Ones in the n lowest bit positions; n may reach sixty-four.
    // A shift by sixty-four is out of range, hence the test of the top bit.
    function [63:0] low_mask;
        input [6:0] n;
        begin
            if (n[6]) begin
                low_mask = {64{1'b1}};
            end else begin
                low_mask = (64'h1 << n) - 64'h1;
            end
        end
    endfunction

    // State, pin synchronisers, timers and the captured request fields.
    reg [2:0] st_q;
    reg [2:0] car_q;
    reg [1:0] mf_q;
    reg [1:0] ms_q;
    reg mod_prev_q;
    reg [7:0] pw_q;
    reg [12:0] dly_q;
    reg [13:0] mit_q;
    reg [3:0] cnt_q;
    reg [7:0] flags_q;
    reg [7:0] cmd_q;
    reg [7:0] mlen_q;
    reg [63:0] mask_q;
    reg first_q;
    reg [3:0] bidx_q;

    // Decoded slot geometry, the UID match and the response path.
    wire tick;
    wire mod_act;
    wire slot_eof;
    wire one_slot;
    wire [3:0] last_slot;
    wire [6:0] sn_width;
    wire [6:0] mlen7;
    wire [3:0] slot_nx;
    wire [63:0] key;
    wire match;
    wire inv_ok;
    wire [6:0] ushift;
    wire [63:0] uid_sh;
    reg [7:0] tx_byte;
    wire buf_ready;
    wire buf_push;
    wire [8:0] buf_out;

    // Two flops on every pin; a third flop on the carrier finds its rising edge.
    // The clk must run more than twice the carrier, or carrier edges are missed.
    always @(posedge clk) begin
        if (!resetn) begin
            car_q <= 3'h0;
            mf_q <= 2'h0;
            ms_q <= 2'h0;
        end else begin
            car_q <= {car_q[1:0], carrier_clk};
            mf_q <= {mf_q[0], mod_full};
            ms_q <= {ms_q[0], mod_shallow};
        end
    end

    // One pulse per carrier cycle paces every delay window.
    assign tick = car_q[1] & ~car_q[2];

    // Either depth counts as a delimiter pulse, shallow only outside the ignore window.
    assign mod_act = mf_q[1] | (ms_q[1] & ~shallow_ignore);

    // The delimiter's rising edge is the end of the modulation pulse.
    assign slot_eof = mod_prev_q & ~mod_act & (pw_q >= EOF_MIN);

    // Measure each modulation pulse in carrier cycles, saturating.
    always @(posedge clk) begin
        if (!resetn) begin
            mod_prev_q <= 1'b0;
            pw_q <= 8'h00;
        end else begin
            mod_prev_q <= mod_act;
            if (!mod_act) begin
                pw_q <= 8'h00;
            end else if (tick && pw_q != 8'hFF) begin
                pw_q <= pw_q + 8'h01;
            end
        end
    end

    // Slot geometry follows the slot-count flag of the request.
    assign one_slot = flags_q[`RITM_FLAG_SLOTS_BIT];
    assign last_slot = one_slot ? 4'h0 : `RITM_LAST_SLOT16;
    assign sn_width = one_slot ? 7'h00 : `RITM_SLOT_W16;
    assign mlen7 = mlen_q[6:0];

    // First slot after the request is zero, later ones step by one.
    assign slot_nx = first_q ? 4'h0 : slot_index + 4'h1;

    // Slot bits sit above the significant mask bits; padding is masked off.
    assign key = (mask_q & low_mask(mlen7)) | ({60'h0, slot_nx} << mlen7);
    assign match = ((uid & low_mask(sn_width + mlen7)) == key);

    // The device answers only a well formed inventory within the mask limits.
    assign inv_ok = flags_q[`RITM_FLAG_INV_BIT] & ~flags_q[`RITM_FLAG_AFI_BIT]
        & (cmd_q == `RITM_CMD_INVENTORY)
        & (mlen_q <= (one_slot ? `RITM_MASK_MAX1 : `RITM_MASK_MAX16));

    // Response bytes: flags, format identifier, then the UID LSB byte first.
    assign ushift = {bidx_q - 4'h2, 3'h0};
    assign uid_sh = uid >> ushift;
    always @* begin
        case (bidx_q)
            4'h0: tx_byte = `RITM_RESP_FLAGS;
            4'h1: tx_byte = `RITM_DSFID;
            default: tx_byte = uid_sh[7:0];
        endcase
    end

    // A stalled receiver holds the sender in ST_SEND until the buffer drains.
    // Pushing from a state rather than a pulse means a full buffer loses no byte.
    assign buf_push = (st_q == ST_SEND);

    ritm_buf2 #(
        .W(9)
    ) u_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(buf_push),
        .in_data({bidx_q == `RITM_RESP_LAST, tx_byte}),
        .in_ready(buf_ready),
        .out_valid(resp_valid),
        .out_data(buf_out),
        .out_ready(resp_ready)
    );

    assign resp_data = buf_out[7:0];
    assign resp_last = buf_out[8];

    // Shallow modulation ignore window, started by each accepted delimiter.
    // Restarting on every delimiter keeps a late pulse from cutting the window short.
    always @(posedge clk) begin
        if (!resetn) begin
            shallow_ignore <= 1'b0;
            mit_q <= 14'h0000;
        end else if ((st_q == ST_RX && rx_eof && rx_crc_ok) ||
                     (st_q == ST_SLOT && slot_eof)) begin
            shallow_ignore <= 1'b1;
            mit_q <= 14'h0000;
        end else if (shallow_ignore && tick) begin
            if (mit_q >= MIT_CYC - 14'h0001) begin
                shallow_ignore <= 1'b0;
            end
            mit_q <= mit_q + 14'h0001;
        end
    end

    // Main sequencer: receive, delay, answer, and wait for slot delimiters.
    always @(posedge clk) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            flags_q <= 8'h00;
            cmd_q <= 8'h00;
            mlen_q <= 8'h00;
            mask_q <= 64'h0;
            first_q <= 1'b0;
            bidx_q <= 4'h0;
            dly_q <= 13'h0000;
            slot_index <= 4'h0;
            inv_active <= 1'b0;
            reply_go <= 1'b0;
        end else begin
            reply_go <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    // Only a frame start leaves idle; stray bytes and delimiters are dropped.
                    if (rx_sof) begin
                        st_q <= ST_RX;
                        cnt_q <= 4'h0;
                        mask_q <= 64'h0;
                    end
                end
                ST_RX: begin
                    // Fields arrive byte by byte; mask bytes fill upward.
                    if (rx_valid) begin
                        if (cnt_q != 4'hF) begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                        case (cnt_q)
                            4'h0: flags_q <= rx_data;
                            4'h1: cmd_q <= rx_data;
                            4'h2: mlen_q <= rx_data;
                            default: begin
                                if (cnt_q < 4'hB &&
                                    {cnt_q - 4'h3, 3'h0} < mlen_q[6:0]) begin
                                    // Whole mask bytes LSB first; CRC bytes skipped.
                                    mask_q[{cnt_q[2:0] - 3'h3, 3'h0} +: 8] <= rx_data;
                                end
                            end
                        endcase
                    end else if (rx_sof) begin
                        cnt_q <= 4'h0;
                        mask_q <= 64'h0;
                    end else if (rx_eof) begin
                        dly_q <= 13'h0000;
                        if (!rx_crc_ok) begin
                            st_q <= ST_IDLE;
                        end else if (flags_q[`RITM_FLAG_INV_BIT]) begin
                            // Any new inventory restarts slot numbering.
                            first_q <= 1'b1;
                            inv_active <= inv_ok;
                            st_q <= inv_ok ? ST_DELAY : ST_IDLE;
                        end else begin
                            first_q <= 1'b0;
                            inv_active <= 1'b0;
                            st_q <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    // The timer counts carrier ticks from the delimiter's rising edge.
                    if (mf_q[1]) begin
                        dly_q <= 13'h0000;
                    end else if (dly_q >= T1_CYC) begin
                        // Fire at the nominal delay, inside the legal window.
                        if (inv_active) begin
                            slot_index <= slot_nx;
                            first_q <= 1'b0;
                            bidx_q <= 4'h0;
                            st_q <= match ? ST_SEND : ST_SLOT;
                        end else if (cmd_q == `RITM_CMD_WRITE) begin
                            st_q <= ST_WRWAIT;
                        end else begin
                            reply_go <= 1'b1;
                            st_q <= ST_IDLE;
                        end
                    end else if (tick) begin
                        dly_q <= dly_q + 13'h0001;
                    end
                end
                ST_SEND: begin
                    // The index advances only when the buffer takes the byte on offer.
                    if (buf_ready) begin
                        bidx_q <= bidx_q + 4'h1;
                        if (bidx_q == `RITM_RESP_LAST) begin
                            st_q <= ST_SLOT;
                        end
                    end
                end
                ST_SLOT: begin
                    // No timer runs here; the reader's guard time paces the delimiters.
                    if (rx_sof) begin
                        // A new frame ends the inventory and is decoded afresh.
                        inv_active <= 1'b0;
                        cnt_q <= 4'h0;
                        mask_q <= 64'h0;
                        st_q <= ST_RX;
                    end else if (slot_eof) begin
                        dly_q <= 13'h0000;
                        if (slot_index < last_slot) begin
                            st_q <= ST_DELAY;
                        end else begin
                            inv_active <= 1'b0;
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_WRWAIT: begin
                    // Write completion, not the most delay, releases the reply.
                    if (write_done) begin
                        reply_go <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- tb/ritm_chk_assertions.sv
// Port checks for the inventory slot sequencer.
// Assumes a bind onto ritm_inventory; carrier edges are seen on clk.
`timescale 1ns/1ns
module ritm_chk #(
    parameter [12:0] T1_CYC = 13'h1100,
    parameter [13:0] MIT_CYC = 14'h1520
) (
    input wire clk,
    input wire resetn,
    input wire carrier_clk,
    input wire mod_full,
    input wire rx_eof,
    input wire rx_crc_ok,
    input wire resp_valid,
    input wire [7:0] resp_data,
    input wire resp_last,
    input wire resp_ready,
    input wire [3:0] slot_index,
    input wire shallow_ignore,
    input wire reply_go
);
    reg [1:0] car_q;
    reg [15:0] dly_q;
    reg [15:0] ign_q;
    reg [3:0] bcnt_q;
    reg arm_q;
    wire tick = car_q[0] & ~car_q[1];
    // Carrier ticks since the last EOF, ticks of ignore, bytes taken.
    // A full burst zeroes the delay count, so a restart widens no window.
    always @(posedge clk) begin
        car_q <= {car_q[0], carrier_clk};
        if (!resetn || rx_eof || mod_full)
            dly_q <= 16'h0000;
        else if (tick && dly_q != 16'hFFFF)
            dly_q <= dly_q + 16'h0001;
        if (!resetn)
            arm_q <= 1'b0;
        else if (rx_eof && rx_crc_ok)
            arm_q <= 1'b1; // A new request arms even after a long idle count.
        else if ($rose(resp_valid) || reply_go || dly_q > T1_CYC + 4)
            arm_q <= 1'b0;
        if (!resetn || !shallow_ignore)
            ign_q <= 16'h0000;
        else if (tick)
            ign_q <= ign_q + 16'h0001;
        if (!resetn)
            bcnt_q <= 4'h0;
        else if (resp_valid && resp_ready)
            bcnt_q <= resp_last ? 4'h0 : bcnt_q + 4'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence hs_s;
        resp_valid && resp_ready;
    endsequence
    sequence stall_s;
        resp_valid && !resp_ready;
    endsequence
    sequence answer_s;
        ($rose(resp_valid) || $rose(reply_go)) && arm_q;
    endsequence
    step_one_a: assert property ($changed(slot_index) |->
        slot_index == $past(slot_index) + 4'h1 || slot_index == 4'h0)
        else $error("slot index jumped");
    hold_stall_a: assert property (stall_s |=>
        resp_valid && $stable(resp_data) && $stable(resp_last))
        else $error("response byte lost in stall");
    ign_start_a: assert property (rx_eof && rx_crc_ok |=> shallow_ignore)
        else $error("ignore window not opened");
    ign_len_a: assert property ($fell(shallow_ignore) |-> ign_q >= MIT_CYC - 1)
        else $error("ignore window too short");
    resp_delay_a: assert property (answer_s |->
        dly_q >= T1_CYC - 1 && dly_q <= T1_CYC + 3)
        else $error("answer outside delay window");
    reply_pulse_a: assert property ($rose(reply_go) |=> !reply_go)
        else $error("reply pulse too long");
    last_flag_a: assert property (hs_s |-> resp_last == (bcnt_q == 4'h9))
        else $error("last flag misplaced");
    lead_zero_a: assert property (hs_s and bcnt_q < 4'h2 |-> resp_data == 8'h00)
        else $error("leading byte not zero");
endmodule
bind ritm_inventory ritm_chk #(.T1_CYC(T1_CYC), .MIT_CYC(MIT_CYC)) i_chk (.clk(clk),
    .resetn(resetn), .carrier_clk(carrier_clk), .mod_full(mod_full), .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready), .slot_index(slot_index),
    .shallow_ignore(shallow_ignore), .reply_go(reply_go));

//--- tb/ritm_reader_model.sv
// Reader model: free carrier, modulation pulses, decoded request frames.
// Assumes the sequencer samples the request port on rising clk.
`timescale 1ns/1ns
module ritm_reader_model (
    input wire clk,
    output reg carrier_clk,
    output reg mod_full,
    output reg mod_shallow,
    output reg rx_sof,
    output reg rx_valid,
    output reg [7:0] rx_data,
    output reg rx_eof,
    output reg rx_crc_ok
);
    // The field stays on, so the carrier runs free at an odd phase.
    initial begin
        {carrier_clk, mod_full, mod_shallow, rx_sof, rx_valid, rx_eof} = 6'h00;
        rx_data = 8'h00;
        rx_crc_ok = 1'b0;
        #7;
        forever #80 carrier_clk = ~carrier_clk;
    end
    // One byte strobe; the released line shows the inverse byte.
    task put(input [7:0] b);
        begin
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_data = b;
            @(posedge clk);
            #1;
            rx_valid = 1'b0;
            rx_data = ~b;
        end
    endtask
    // Whole request frame after the guard time.
    task req(input [7:0] fl, input [7:0] cmd, input [7:0] len, input [63:0] m, input ok);
        integer k;
        begin
            // Scaled guard: covers power-up, a quiet request and a tag answer alike.
            repeat (30) @(posedge carrier_clk);
            @(posedge clk);
            #1;
            rx_sof = 1'b1;
            @(posedge clk);
            #1;
            rx_sof = 1'b0;
            put(fl);
            put(cmd);
            put(len);
            for (k = 0; k < (len + 7) / 8; k = k + 1)
                put(m[8*k +: 8]);
            put(8'hA5);
            put(8'h5A);
            @(posedge clk);
            #1;
            rx_eof = 1'b1;
            rx_crc_ok = ok;
            @(posedge clk);
            #1;
            rx_eof = 1'b0;
            rx_crc_ok = ~ok;
        end
    endtask
    // Waits twenty carrier ticks, then a delimiter of four ticks.
    task slot_eof(input full);
        begin
            repeat (20) @(posedge carrier_clk);
            mod_full = full;
            mod_shallow = ~full;
            repeat (4) @(posedge carrier_clk);
            mod_full = 1'b0;
            mod_shallow = 1'b0;
        end
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the inventory slot sequencer.
// Assumes the reader model drives the request port and the carrier.
`timescale 1ns/1ns
module tb_top;
    localparam [63:0] UID = 64'h0011_2233_4455_6D27;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg resp_ready = 1'b0;
    reg write_done = 1'b0;
    reg [63:0] tag_uid = UID;
    wire carrier_clk, mod_full, mod_shallow, rx_sof, rx_valid, rx_eof, rx_crc_ok;
    wire resp_valid, resp_last, inv_active, shallow_ignore, reply_go;
    wire [7:0] rx_data;
    wire [7:0] resp_data;
    wire [3:0] slot_index;
    integer fails = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer gos = 0;
    reg [7:0] rq[$];
    always #10 clk = ~clk;
    ritm_reader_model i_rdr (.clk(clk), .carrier_clk(carrier_clk), .mod_full(mod_full),
        .mod_shallow(mod_shallow), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok));
    // Short windows keep sixteen slots well inside the run limit.
    ritm_inventory #(.T1_CYC(13'h0028), .MIT_CYC(14'h003C), .EOF_MIN(8'h02)) i_dut (
        .clk(clk), .resetn(resetn), .carrier_clk(carrier_clk), .mod_full(mod_full),
        .mod_shallow(mod_shallow), .uid(tag_uid), .rx_sof(rx_sof), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .write_done(write_done),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
        .resp_ready(resp_ready), .slot_index(slot_index), .inv_active(inv_active),
        .shallow_ignore(shallow_ignore), .reply_go(reply_go));
    // Receiver stalls one cycle in four; the run is cut off if it hangs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (resp_valid === 1'b1 && resp_ready)
            rq.push_back(resp_data);
        if (reply_go === 1'b1)
            gos = gos + 1;
        resp_ready <= #1 (cyc % 4 != 3);
        if (cyc == 60000) begin
            fails = fails + 1;
            $display("BAD %0t run timed out", $time);
            end_sim;
        end
    end
    task chk(input [63:0] got, input [63:0] exp, input [8*12-1:0] what);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("BAD %0t %0s got %0h exp %0h", $time, what, got, exp);
            end
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n) @(posedge carrier_clk);
            @(posedge clk);
            #1;
        end
    endtask
    // Full answers are two zero bytes then the UID, low byte first.
    task chk_resp(input integer n);
        integer k;
        begin
            chk(rq.size(), n, "resp count");
            for (k = 0; k < rq.size() && n == 10; k = k + 1)
                chk(rq[k], k < 2 ? 8'h00 : UID[8*(k-2) +: 8], "resp byte");
            rq.delete();
        end
    endtask
    // Sixteen slots; slot bits above the mask must meet the UID in slot 2.
    task t_sixteen;
        integer s;
        begin
            i_rdr.req(8'h04, 8'h01, 8'h04, 64'h7, 1'b1);
            ticks(50);
            for (s = 0; s < 16; s = s + 1) begin
                chk(slot_index, s, "slot");
                chk(inv_active, 1, "active");
                chk_resp(s == 2 ? 10 : 0);
                i_rdr.slot_eof(s[0]);
                ticks(50);
            end
            chk(inv_active, 0, "ended");
            chk_resp(0);
        end
    endtask
    // One slot, zero padding where the UID has ones, and a burst that restarts the delay.
    task t_single;
        begin
            i_rdr.req(8'h24, 8'h01, 8'h0C, 64'h0D27, 1'b1);
            chk(shallow_ignore, 1, "ignore");
            i_rdr.slot_eof(1'b1);
            ticks(30);
            chk_resp(0);
            ticks(20);
            chk_resp(10);
            chk(slot_index, 0, "one slot");
            i_rdr.slot_eof(1'b0);
            ticks(5);
            chk(inv_active, 0, "one ended");
        end
    endtask
    // Abort in slot 1, a silent bad CRC, then numbering from zero again.
    task t_abort;
        begin
            i_rdr.req(8'h04, 8'h01, 8'h00, 64'h0, 1'b1);
            ticks(50);
            i_rdr.slot_eof(1'b0);
            ticks(50);
            chk(slot_index, 1, "slot one");
            gos = 0;
            i_rdr.req(8'h00, 8'h23, 8'h00, 64'h0, 1'b1);
            chk(inv_active, 0, "aborted");
            ticks(50);
            chk(gos, 1, "reply");
            i_rdr.req(8'h04, 8'h01, 8'h00, 64'h0, 1'b0);
            ticks(50);
            chk(inv_active, 0, "crc bad");
            i_rdr.req(8'h04, 8'h01, 8'h00, 64'h0, 1'b1);
            ticks(50);
            chk(slot_index, 0, "restart");
            chk(inv_active, 1, "restarted");
            chk_resp(0);
        end
    endtask
    // A write stays silent past the most delay until its completion is signalled.
    task t_write;
        begin
            gos = 0;
            i_rdr.req(8'h00, 8'h21, 8'h00, 64'h0, 1'b1);
            ticks(100);
            chk(gos, 0, "write early");
            write_done = 1'b1;
            @(posedge clk);
            #1;
            write_done = 1'b0;
            ticks(2);
            chk(gos, 1, "write reply");
        end
    endtask
    task end_sim;
        begin
            if (fails == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_sixteen;
        t_single;
        t_abort;
        t_write;
        end_sim;
    end
endmodule
